// ---- core/udt_pkg.sv ----
// Package with register map, field layouts and constants of the up/down encoder timer
package udt_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int CHANNELS = 2;        // Two independent channels
    localparam int DATA_W = 16;         // Counter and register width
    localparam int ADDR_W = 6;          // [5:4] group, [3:0] register index
    localparam int IRQ_PER_CH = 4;      // Two compare plus two capture/compare

    // ************************************************************
    // Address map
    // ************************************************************
    localparam logic [1:0] GRP_GLOBAL = 2'h2;         // Group of shared registers
    localparam logic [3:0] OFF_CTRL = 4'h0;           // counter_control_reg
    localparam logic [3:0] OFF_PRESCALE = 4'h1;       // prescaler_mode_reg
    localparam logic [3:0] OFF_EDGE = 4'h2;           // Capture edge select
    localparam logic [3:0] OFF_CAPSEL = 4'h3;         // capture_select_reg
    localparam logic [3:0] OFF_COUNTER = 4'h4;        // updown_counter
    localparam logic [3:0] OFF_CMP_FIRST = 4'h5;      // compare_first
    localparam logic [3:0] OFF_CMP_SECOND = 4'h6;     // compare_second
    localparam logic [3:0] OFF_CC_FIRST = 4'h7;       // capcomp_first
    localparam logic [3:0] OFF_CC_SECOND = 4'h8;      // capcomp_second
    localparam logic [3:0] OFF_FLAG = 4'h9;           // flag_reg
    localparam logic [3:0] OFF_BASE_CLK = 4'h0;       // Global: base_clock_select

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int FLAG_DIR = 0;        // Last count direction, 1 = down
    localparam int FLAG_OVF = 1;        // Sticky wrap flag
    localparam int EDGE_FIRST_LSB = 0;  // Edge select of capture_pin_first
    localparam int EDGE_SECOND_LSB = 2; // Edge select of the second trigger
    localparam logic [1:0] EDGE_RISE = 2'h1;          // Bit0 rising, bit1 falling
    localparam logic [1:0] CLR_EXT_ONLY = 2'h0;       // Mode A clear codes
    localparam logic [1:0] CLR_MATCH_UP = 2'h1;
    localparam logic [1:0] CLR_BOTH = 2'h2;
    localparam logic [1:0] BASE_DIV4_LAST = 2'h3;     // Last state of the /4 divider
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ALL_ONES16 = 16'hffff;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [7:0] PRE_BASE = 8'h02;          // Smallest prescaler ratio
    localparam logic [7:0] PRE_ONE = 8'h01;

    // Control register layout, bit 0 first from the bottom
    typedef struct packed {
        logic active_high;          // Bit 7: pulse output active level
        logic out_enable;           // Bit 6: pulse output enable
        logic clear_select_high;    // Bit 5
        logic clear_select_low;     // Bit 4
        logic match_clear_enable;   // Bit 3: general-purpose clear on first match
        logic udc_mode_b;           // Bit 2: up/down mode B
        logic updown_count_mode;    // Bit 1: 1 = encoder up/down mode
        logic count_run_bit;        // Bit 0: run
    } udt_ctrl_t;

    localparam udt_ctrl_t CTRL_RESET = '0;

endpackage

// ---- core/udt_edge.sv ----
// Edge detector with selectable valid edge, registered pulse output
`timescale 1ns/100ps
module udt_edge (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic level_i,
    input wire logic [1:0] sel_i,
    output logic pulse_o
);

    logic prev; // Level one cycle ago

    // ************************************************************
    // Edge detection
    // ************************************************************
    // Bit 0 of the select takes rising edges, bit 1 falling ones
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            prev <= 1'b0;
            pulse_o <= 1'b0;
        end else begin
            prev <= level_i;
            pulse_o <= (sel_i[0] & level_i & ~prev) | (sel_i[1] & ~level_i & prev);
        end
    end

endmodule // udt_edge

// ---- core/udt_prescaler.sv ----
// Count clock prescaler giving a one-cycle tick every 2 to 256 base clocks
`timescale 1ns/100ps
module udt_prescaler (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic base_en_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);

    logic [7:0] cnt;   // Base clock count
    logic [7:0] limit; // Last count before a tick

    // Ratio is two shifted up by the select
    assign limit = (udt_pkg::PRE_BASE << sel_i) - udt_pkg::PRE_ONE;

    // ************************************************************
    // Divider
    // ************************************************************
    // Stopping holds the divider in its initial state, so every start
    // gives a full first period
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            cnt <= 8'h00;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt <= 8'h00;
            tick_o <= 1'b0;
        end else if (base_en_i) begin
            if (cnt == limit) begin
                cnt <= 8'h00;
                tick_o <= 1'b1;
            end else begin
                cnt <= cnt + 8'h01;
                tick_o <= 1'b0;
            end
        end else begin
            tick_o <= 1'b0;
        end
    end

endmodule // udt_prescaler

// ---- core/udt_top.sv ----
// Two-channel 16-bit up/down encoder timer with register port
`timescale 1ns/100ps

// How it works
// - Two independent 16-bit up/down counters
// - Timer mode counts up; encoder mode both ways
// - Base clock is system clock /2 or /4
// - Prescaler divides base by 2 to 256
// - Timer mode: optional clear on first match
// - Mode B: first match up, second down
// - Mode A code 00: external clear only
// - Mode A: first match, or both sources
// - Capture pin edge latches counter value
// - Second capture source selectable between pins
// - Four separate interrupt requests per channel
// - Timer mode drives 16-bit PWM output
// - Rewriting configuration registers is harmless
// - Run bit starts and stops counting
// - Encoder input a clocks, b gives direction
// - Mode A clear field codes 00/01/10; code 11 clears nothing
// - Base select 0 is /4, 1 is /2
module udt_top (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [udt_pkg::ADDR_W-1:0] addr_i,
    input wire logic [udt_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [udt_pkg::DATA_W-1:0] rdata_o,
    input wire logic [udt_pkg::CHANNELS-1:0] capture_pin_first_i,
    input wire logic [udt_pkg::CHANNELS-1:0] capture_pin_second_i,
    input wire logic [udt_pkg::CHANNELS-1:0] encoder_input_a_i,
    input wire logic [udt_pkg::CHANNELS-1:0] encoder_input_b_i,
    input wire logic [udt_pkg::CHANNELS-1:0] external_clear_pin_i,
    output logic [udt_pkg::CHANNELS-1:0] pulse_output_pin_o,
    output logic [udt_pkg::CHANNELS*udt_pkg::IRQ_PER_CH-1:0] irq_o
);

    // ************************************************************
    // Register storage
    // ************************************************************
    udt_pkg::udt_ctrl_t ctrl [udt_pkg::CHANNELS];       // counter_control_reg
    logic [2:0] prescale_select [udt_pkg::CHANNELS];    // prescaler_mode_reg
    logic [3:0] edge_sel [udt_pkg::CHANNELS];           // Capture valid edges
    logic capture_source_select [udt_pkg::CHANNELS];    // capture_select_reg
    logic [15:0] updown_counter [udt_pkg::CHANNELS];    // Counters
    logic [15:0] compare_first [udt_pkg::CHANNELS];
    logic [15:0] compare_second [udt_pkg::CHANNELS];
    logic [15:0] capcomp_first [udt_pkg::CHANNELS];
    logic [15:0] capcomp_second [udt_pkg::CHANNELS];
    logic [1:0] flag_reg [udt_pkg::CHANNELS];           // Direction and wrap
    logic base_clock_select;                            // Shared by both channels

    // ************************************************************
    // Base clock
    // ************************************************************
    logic [1:0] base_div; // Free-running divider
    logic base_en;        // One-cycle base clock enable

    // Free running, so changing the select never stalls the base clock
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            base_div <= 2'h0;
        end else begin
            base_div <= base_div + 2'h1;
        end
    end

    // Select 1 gives every second cycle, 0 every fourth
    assign base_en = base_clock_select ? base_div[0] :
                     (base_div == udt_pkg::BASE_DIV4_LAST);

    // Global register write
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            base_clock_select <= 1'b0;
        end else if (wr_i && addr_i[5:4] == udt_pkg::GRP_GLOBAL &&
                     addr_i[3:0] == udt_pkg::OFF_BASE_CLK) begin
            base_clock_select <= wdata_i[0];
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    for (genvar ch = 0; ch < udt_pkg::CHANNELS; ch++) begin : g_ch
        logic sel_ch;      // Access targets this channel
        logic cap0_ev;     // Valid edge on the first capture trigger
        logic cap1_ev;     // Valid edge on the second capture trigger
        logic cap1_level;  // Chosen second trigger level
        logic enc_ev;      // Rising edge of encoder input a
        logic clr_ev;      // Rising edge of external clear
        logic tick;        // Prescaled count clock
        logic step;        // Counter advances this cycle
        logic down;        // Current direction
        logic match0;      // Counter equals compare_first
        logic match1;      // Counter equals compare_second
        logic clr_match;   // Compare clear for this step
        logic clr_ext;     // External clear taken
        logic wrap;        // Step passes the end of range
        logic [1:0] clr_field; // Mode A clear select

        assign sel_ch = (addr_i[5:4] == 2'(ch));
        assign clr_field = {ctrl[ch].clear_select_high, ctrl[ch].clear_select_low};

        // Second trigger can follow the first pin instead of its own
        assign cap1_level = capture_source_select[ch] ? capture_pin_first_i[ch] :
                            capture_pin_second_i[ch];

        udt_edge u_cap0 (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .level_i(capture_pin_first_i[ch]),
            .sel_i(edge_sel[ch][udt_pkg::EDGE_FIRST_LSB +: 2]),
            .pulse_o(cap0_ev)
        );

        udt_edge u_cap1 (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .level_i(cap1_level),
            .sel_i(edge_sel[ch][udt_pkg::EDGE_SECOND_LSB +: 2]),
            .pulse_o(cap1_ev)
        );

        udt_edge u_enc (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .level_i(encoder_input_a_i[ch]),
            .sel_i(udt_pkg::EDGE_RISE),
            .pulse_o(enc_ev)
        );

        udt_edge u_clr (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .level_i(external_clear_pin_i[ch]),
            .sel_i(udt_pkg::EDGE_RISE),
            .pulse_o(clr_ev)
        );

        udt_prescaler u_pre (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .run_i(ctrl[ch].count_run_bit),
            .base_en_i(base_en),
            .sel_i(prescale_select[ch]),
            .tick_o(tick)
        );

        // Encoder mode steps on input a, timer mode on the prescaler tick
        assign step = ctrl[ch].count_run_bit &
                      (ctrl[ch].updown_count_mode ? enc_ev : tick);
        // Input b is the phase: high counts down; timer mode only counts up
        assign down = ctrl[ch].updown_count_mode & encoder_input_b_i[ch];
        assign match0 = (updown_counter[ch] == compare_first[ch]);
        assign match1 = (updown_counter[ch] == compare_second[ch]);

        // Clear source for the current mode
        always_comb begin
            clr_match = 1'b0;
            if (!ctrl[ch].updown_count_mode) begin
                clr_match = ctrl[ch].match_clear_enable & match0;
            end else if (ctrl[ch].udc_mode_b) begin
                clr_match = (~down & match0) | (down & match1);
            end else if (clr_field == udt_pkg::CLR_MATCH_UP ||
                         clr_field == udt_pkg::CLR_BOTH) begin
                clr_match = ~down & match0;
            end
        end

        // External clear only in mode A with code 00 or 10
        assign clr_ext = ctrl[ch].count_run_bit & ctrl[ch].updown_count_mode &
                         ~ctrl[ch].udc_mode_b & clr_ev &
                         (clr_field == udt_pkg::CLR_EXT_ONLY ||
                          clr_field == udt_pkg::CLR_BOTH);
        assign wrap = down ? (updown_counter[ch] == udt_pkg::ZERO16) :
                      (updown_counter[ch] == udt_pkg::ALL_ONES16);

        // Configuration writes; a rewrite of the same value changes nothing
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                ctrl[ch] <= udt_pkg::CTRL_RESET;
                prescale_select[ch] <= 3'h0;
                edge_sel[ch] <= 4'h0;
                capture_source_select[ch] <= 1'b0;
                compare_first[ch] <= udt_pkg::ZERO16;
                compare_second[ch] <= udt_pkg::ZERO16;
            end else if (wr_i && sel_ch) begin
                case (addr_i[3:0])
                    udt_pkg::OFF_CTRL: begin
                        ctrl[ch] <= udt_pkg::udt_ctrl_t'(wdata_i[7:0]);
                    end
                    udt_pkg::OFF_PRESCALE: begin
                        prescale_select[ch] <= wdata_i[2:0];
                    end
                    udt_pkg::OFF_EDGE: begin
                        edge_sel[ch] <= wdata_i[3:0];
                    end
                    udt_pkg::OFF_CAPSEL: begin
                        capture_source_select[ch] <= wdata_i[0];
                    end
                    udt_pkg::OFF_CMP_FIRST: begin
                        compare_first[ch] <= wdata_i;
                    end
                    udt_pkg::OFF_CMP_SECOND: begin
                        compare_second[ch] <= wdata_i;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Counter: external clear, then step, then software load when stopped
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                updown_counter[ch] <= udt_pkg::ZERO16;
            end else if (clr_ext) begin
                updown_counter[ch] <= udt_pkg::ZERO16;
            end else if (step) begin
                if (clr_match) begin
                    updown_counter[ch] <= udt_pkg::ZERO16;
                end else if (down) begin
                    updown_counter[ch] <= updown_counter[ch] - udt_pkg::ONE16;
                end else begin
                    updown_counter[ch] <= updown_counter[ch] + udt_pkg::ONE16;
                end
            end else if (wr_i && sel_ch && addr_i[3:0] == udt_pkg::OFF_COUNTER &&
                         !ctrl[ch].count_run_bit) begin
                // Writes while running are dropped to keep the count coherent
                updown_counter[ch] <= wdata_i;
            end
        end

        // Capture/compare registers: a capture beats a software write
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                capcomp_first[ch] <= udt_pkg::ZERO16;
                capcomp_second[ch] <= udt_pkg::ZERO16;
            end else begin
                if (cap0_ev) begin
                    capcomp_first[ch] <= updown_counter[ch];
                end else if (wr_i && sel_ch && addr_i[3:0] == udt_pkg::OFF_CC_FIRST) begin
                    capcomp_first[ch] <= wdata_i;
                end
                if (cap1_ev) begin
                    capcomp_second[ch] <= updown_counter[ch];
                end else if (wr_i && sel_ch && addr_i[3:0] == udt_pkg::OFF_CC_SECOND) begin
                    capcomp_second[ch] <= wdata_i;
                end
            end
        end

        // Interrupt requests, one-cycle pulses, captures in the latch cycle
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                irq_o[ch*udt_pkg::IRQ_PER_CH +: udt_pkg::IRQ_PER_CH] <= 4'h0;
            end else begin
                irq_o[ch*udt_pkg::IRQ_PER_CH +: udt_pkg::IRQ_PER_CH] <=
                    {cap1_ev, cap0_ev, step & match1, step & match0};
            end
        end

        // Flags: direction follows each step, wrap is sticky, set wins over clear
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                flag_reg[ch] <= 2'h0;
            end else begin
                if (step) begin
                    flag_reg[ch][udt_pkg::FLAG_DIR] <= down;
                end
                if (step && wrap && !clr_match) begin
                    flag_reg[ch][udt_pkg::FLAG_OVF] <= 1'b1;
                end else if (wr_i && sel_ch && addr_i[3:0] == udt_pkg::OFF_FLAG &&
                             !wdata_i[udt_pkg::FLAG_OVF]) begin
                    flag_reg[ch][udt_pkg::FLAG_OVF] <= 1'b0;
                end
            end
        end

        // PWM: active below compare_second, period set by first-match clear;
        // encoder mode or disabled output parks at the inactive level
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                pulse_output_pin_o[ch] <= 1'b0;
            end else if (ctrl[ch].out_enable && !ctrl[ch].updown_count_mode) begin
                pulse_output_pin_o[ch] <= (updown_counter[ch] < compare_second[ch]) ?
                    ctrl[ch].active_high : ~ctrl[ch].active_high;
            end else begin
                pulse_output_pin_o[ch] <= ~ctrl[ch].active_high;
            end
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [0:0] rch; // Channel index of the read address

    assign rch = addr_i[4];

    // Data in the cycle after the strobe only; unmapped reads give zero.
    // Reads have no side effects, so repeated reads are safe here
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !rd_i) begin
            rdata_o <= udt_pkg::ZERO16;
        end else if (addr_i[5:4] == udt_pkg::GRP_GLOBAL) begin
            rdata_o <= (addr_i[3:0] == udt_pkg::OFF_BASE_CLK) ?
                       {15'h0000, base_clock_select} : udt_pkg::ZERO16;
        end else if (addr_i[5]) begin
            rdata_o <= udt_pkg::ZERO16;
        end else begin
            case (addr_i[3:0])
                udt_pkg::OFF_CTRL: begin
                    rdata_o <= {8'h00, ctrl[rch]};
                end
                udt_pkg::OFF_PRESCALE: begin
                    rdata_o <= {13'h0000, prescale_select[rch]};
                end
                udt_pkg::OFF_EDGE: begin
                    rdata_o <= {12'h000, edge_sel[rch]};
                end
                udt_pkg::OFF_CAPSEL: begin
                    rdata_o <= {15'h0000, capture_source_select[rch]};
                end
                udt_pkg::OFF_COUNTER: begin
                    rdata_o <= updown_counter[rch];
                end
                udt_pkg::OFF_CMP_FIRST: begin
                    rdata_o <= compare_first[rch];
                end
                udt_pkg::OFF_CMP_SECOND: begin
                    rdata_o <= compare_second[rch];
                end
                udt_pkg::OFF_CC_FIRST: begin
                    rdata_o <= capcomp_first[rch];
                end
                udt_pkg::OFF_CC_SECOND: begin
                    rdata_o <= capcomp_second[rch];
                end
                udt_pkg::OFF_FLAG: begin
                    rdata_o <= {14'h0000, flag_reg[rch]};
                end
                default: begin
                    rdata_o <= udt_pkg::ZERO16;
                end
            endcase
        end
    end

endmodule // udt_top

// ---- test/udt_chk_assertions.sv ----
// Port checker for the up/down encoder timer
`timescale 1ns/100ps
module udt_chk (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [udt_pkg::ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [udt_pkg::DATA_W-1:0] rdata_o,
    input wire logic [udt_pkg::CHANNELS-1:0] capture_pin_first_i,
    input wire logic [udt_pkg::CHANNELS-1:0] capture_pin_second_i,
    input wire logic [udt_pkg::CHANNELS*udt_pkg::IRQ_PER_CH-1:0] irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic [7:0] hf; // Four past samples of the first pins
    logic [7:0] hs; // Four past samples of the second pins
    // Pin history; zeroed in reset so it never carries unknowns
    always_ff @(posedge clock_i) begin
        hf <= nrst_i ? {hf[5:0], capture_pin_first_i} : '0;
        hs <= nrst_i ? {hs[5:0], capture_pin_second_i} : '0;
    end
    // A capture must follow a pin change within the last few cycles
    wire [1:0] fc = (hf[1:0] ^ hf[7:6]) | (capture_pin_first_i ^ hf[1:0]);
    wire [1:0] sc = (hs[1:0] ^ hs[7:6]) | (capture_pin_second_i ^ hs[1:0]);
    sequence unmapped_rd;
        rd_i && addr_i[5:4] == 2'h3;
    endsequence
    sequence capsel_rd;
        rd_i && !addr_i[5] && addr_i[3:0] == 4'h3;
    endsequence
    idle_rdata_a: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data outside its slot");
    irq_pulse_a: assert property ((irq_o & $past(irq_o)) == '0)
        else $error("interrupt longer than one cycle");
    cap_first0_a: assert property (irq_o[2] |-> fc[0])
        else $error("capture without pin edge ch0");
    cap_first1_a: assert property (irq_o[6] |-> fc[1])
        else $error("capture without pin edge ch1");
    cap_second0_a: assert property (irq_o[3] |-> fc[0] || sc[0])
        else $error("second capture without edge ch0");
    cap_second1_a: assert property (irq_o[7] |-> fc[1] || sc[1])
        else $error("second capture without edge ch1");
    unmap_read_a: assert property (unmapped_rd |=> rdata_o == '0)
        else $error("unmapped read not zero");
    base_read_a: assert property (rd_i && addr_i == 6'h20 |=> rdata_o[15:1] == '0)
        else $error("base select has extra bits");
    capsel_read_a: assert property (capsel_rd |=> rdata_o[15:1] == '0)
        else $error("capture select has extra bits");
endmodule // udt_chk
bind udt_top udt_chk chk (.clock_i, .nrst_i, .addr_i, .rd_i, .rdata_o, .capture_pin_first_i,
    .capture_pin_second_i, .irq_o);

// ---- test/udt_far.sv ----
// Far-side model: encoder, clear and capture pins, alike on both channels
`timescale 1ns/100ps
module udt_far (
    input wire logic clock_i,
    output logic [1:0] enc_a_o,
    output logic [1:0] enc_b_o,
    output logic [1:0] clr_o,
    output logic [1:0] cf_o,
    output logic [1:0] cs_o
);
    initial begin
        {enc_a_o, enc_b_o, clr_o, cf_o, cs_o} = '0;
    end
    // Direction settles before input a rises, so no step is misread
    task automatic step(input logic down);
        @(posedge clock_i) enc_b_o <= {2{down}};
        repeat (2) @(posedge clock_i) enc_a_o <= 2'h3;
        repeat (2) @(posedge clock_i) enc_a_o <= 2'h0;
    endtask
    // Clear pulse on the external clear pin
    task automatic clear();
        @(posedge clock_i) clr_o <= 2'h3;
        repeat (2) @(posedge clock_i) clr_o <= 2'h0;
    endtask
    // Rising edge on the first capture pin, left high
    task automatic capture();
        @(posedge clock_i) cf_o <= 2'h3;
        repeat (4) @(posedge clock_i);
    endtask
endmodule // udt_far

// ---- test/tb_top.sv ----
// Self-checking bench for the up/down encoder timer
`timescale 1ns/100ps
module tb_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] addr_i = '0;
    logic [15:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o, got, hold;
    logic [1:0] a, b, clr, cf, cs, pwm;
    logic [7:0] irq_o, seen = '0;
    int n_errors = 0;
    int checks = 0;
    always #2 clock_i = ~clock_i;
    // Sticky record of every interrupt pulse
    always @(posedge clock_i) if (nrst_i) seen <= seen | irq_o;
    udt_far far (.clock_i(clock_i), .enc_a_o(a), .enc_b_o(b), .clr_o(clr), .cf_o(cf), .cs_o(cs));
    udt_top DUT (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_pin_first_i(cf),
        .capture_pin_second_i(cs), .encoder_input_a_i(a), .encoder_input_b_i(b),
        .external_clear_pin_i(clr), .pulse_output_pin_o(pwm), .irq_o(irq_o));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] val);
        checks++;
        if (val !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, val);
        end
    endtask
    task automatic wr(input logic [5:0] ad, input logic [15:0] d);
        @(posedge clock_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, ad, d};
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] ad);
        @(posedge clock_i);
        {rd_i, addr_i} <= {1'b1, ad};
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask
    task automatic rdc(input string what, input logic [5:0] ad, input logic [15:0] exp);
        rd(ad);
        check(what, exp, got);
    endtask
    // Counter may only be loaded while stopped
    task automatic setup(input logic [15:0] ctl, input logic [15:0] cnt);
        wr(6'h00, 16'h0000);
        wr(6'h04, cnt);
        wr(6'h00, ctl);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock_i);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rdc("ctrl", 6'h00, 16'h0000);
        rdc("base", 6'h20, 16'h0000);
        rdc("unmapped", 6'h35, 16'h0000);
        // Sixteen count periods for each base clock and prescaler codes 0 to 2
        for (int bs = 0; bs < 2; bs++) begin
            for (int p = 0; p < 3; p++) begin
                wr(6'h20, 16'(bs));
                wr(6'h01, 16'(p));
                setup(16'h0001, 16'h0020);
                repeat (16 * (bs ? 2 : 4) * (2 << p)) @(posedge clock_i);
                wr(6'h00, 16'h0000);
                rd(6'h04);
                check("rate", 16'h0001, {15'h0, got >= 47 && got <= 48});
            end
        end
        hold = got;
        repeat (64) @(posedge clock_i);
        rd(6'h09);
        rdc("stopped", 6'h04, hold);
        wr(6'h05, 16'h0003);
        wr(6'h01, 16'h0000);
        setup(16'h0009, 16'h0000);
        repeat (100) @(posedge clock_i);
        rd(6'h04);
        check("match_clr", 16'h0001, {15'h0, got <= 3});
        setup(16'h0033, 16'h0010);
        for (int i = 0; i < 7; i++) far.step(i > 4);
        wr(6'h04, 16'h0077);
        rdc("enc_count", 6'h04, 16'h0013);
        rdc("direction", 6'h09, 16'h0001);
        wr(6'h00, 16'h0003);
        far.clear();
        rdc("ext_clear", 6'h04, 16'h0000);
        setup(16'h0013, 16'h0001);
        for (int i = 0; i < 4; i++) far.step(1'b0);
        rdc("clr_up", 6'h04, 16'h0001);
        wr(6'h06, 16'h0002);
        setup(16'h0007, 16'h0005);
        for (int i = 0; i < 4; i++) far.step(1'b1);
        rdc("clr_down", 6'h04, 16'h0000);
        setup(16'h00c0, 16'h0abc);
        wr(6'h02, 16'h0005);
        wr(6'h03, 16'h0001);
        rdc("capsel", 6'h03, 16'h0001);
        far.capture();
        rdc("cap_first", 6'h07, 16'h0abc);
        rdc("cap_second", 6'h08, 16'h0abc);
        check("irqs", 16'h000f, {8'h0, seen});
        wr(6'h06, 16'h0abd);
        repeat (4) @(posedge clock_i);
        check("pwm_on", 16'h0003, {14'h0, pwm});
        wr(6'h06, 16'h0abc);
        repeat (4) @(posedge clock_i);
        check("pwm_off", 16'h0002, {14'h0, pwm});
        wrap_up();
    end
endmodule // tb_top
